// ---- timer16.sv ----
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module timer16 (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       sleep,
	input  wire logic [1:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       ext_clock_pin,
	input  wire logic       crystal_input_pin,
	output logic            crystal_output_pin,
	output logic            crystal_output_oe,
	output logic            overflow_flag,
	output logic            wake,
	output logic            timebase_valid,
	output logic     [15:0] count
);
	timer16_pkg::timer_control_s ctrl_reg, ctrl_next;
	logic [15:0] count_reg, count_next;
	logic [2:0]  presc_reg, presc_next;
	logic [1:0]  phase_reg, phase_next;
	logic        ovf_reg, ovf_next;
	logic        armed_reg, armed_next;
	logic [7:0]  rdata_reg, rdata_next;
	logic        s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
	logic        osc_reg, osc_next;
	logic        sel_pin, ext_rise, ext_fall, src_tick, presc_out, inc;
	logic        wr_count, async_mode;
	logic [2:0]  presc_mask;

	// crystal amplifier: inverting stage, free of sleep
	always_comb begin
		osc_next = ctrl_reg.crystal_osc_enable & ~crystal_input_pin; // R14
	end

	assign crystal_output_pin = osc_reg;
	assign crystal_output_oe  = ctrl_reg.crystal_osc_enable; // R14

	assign sel_pin = ctrl_reg.crystal_osc_enable ? crystal_input_pin : ext_clock_pin; // R5

	// only s2/s3 agreement updates the level, so a one-sample glitch never counts
	always_comb begin
		lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
		ext_rise = (s2_reg == s3_reg) & s3_reg & ~lvl_reg; // R3
		ext_fall = (s2_reg == s3_reg) & ~s3_reg & lvl_reg;
	end

	assign async_mode = ctrl_reg.clock_source_select & ctrl_reg.ext_sync_disable;
	assign wr_count = wr & ((addr == timer16_pkg::ADDR_COUNT_LO) |
		(addr == timer16_pkg::ADDR_COUNT_HI));

	always_comb begin
		phase_next = phase_reg + 2'h1;
		armed_next = armed_reg;
		if (!ctrl_reg.counter_run || !ctrl_reg.clock_source_select) begin
			armed_next = 1'b0;
		end else if (ext_fall) begin
			armed_next = 1'b1; // R4
		end
	end

	// timer mode ignores sync bit; core stopped in sleep
	always_comb begin
		if (!ctrl_reg.clock_source_select) begin
			src_tick = ~sleep & (phase_reg == timer16_pkg::PHASE_LAST); // R1 R2
		end else begin
			src_tick = ext_rise & armed_reg; // R3 R4
		end
	end

	// prescaler models the ripple chain; keeps counting in sleep on the external source, stops in timer mode
	assign presc_mask = (3'h1 << ctrl_reg.prescale) - 3'h1;
	assign presc_out = src_tick & ((presc_reg & presc_mask) == presc_mask); // R7

	// synchroniser sits after the prescaler, stopped in sleep
	assign inc = ctrl_reg.counter_run & presc_out & (async_mode | ~sleep); // R6 R8 R9 R18

	always_comb begin
		presc_next = presc_reg;
		if (wr_count) begin
			presc_next = timer16_pkg::PRESC_RESET; // R16
		end else if (ctrl_reg.counter_run && src_tick) begin
			presc_next = presc_out ? timer16_pkg::PRESC_RESET : presc_reg + 3'h1; // R7 R8
		end
	end

	// a write beats a concurrent increment; see stop-before-write
	always_comb begin
		count_next = count_reg;
		ovf_next = ovf_reg;
		if (inc) begin
			count_next = count_reg + 16'h0001; // R19
		end
		if (wr && addr == timer16_pkg::ADDR_COUNT_LO) begin
			count_next = {count_reg[15:8], wdata}; // R13
		end else if (wr && addr == timer16_pkg::ADDR_COUNT_HI) begin
			count_next = {wdata, count_reg[7:0]};
		end
		if (wr && addr == timer16_pkg::ADDR_STATUS && wdata[timer16_pkg::BIT_OVF]) begin
			ovf_next = 1'b0;
		end
		if (inc && !wr_count && count_reg == timer16_pkg::COUNT_MAX) begin
			ovf_next = 1'b1; // R19
		end
	end

	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr && addr == timer16_pkg::ADDR_CONTROL) begin
			ctrl_next = wdata;
			ctrl_next.unused = 2'h0;
		end
	end

	// reads see the registered count one byte at a time; nothing latches the other byte
	always_comb begin
		case (addr)
			timer16_pkg::ADDR_CONTROL:  rdata_next = ctrl_reg;
			timer16_pkg::ADDR_COUNT_LO: rdata_next = count_reg[7:0]; // R11
			timer16_pkg::ADDR_COUNT_HI: rdata_next = count_reg[15:8]; // R11
			timer16_pkg::ADDR_STATUS:   rdata_next = {7'h00, ovf_reg};
			default:                    rdata_next = 8'h00;
		endcase
		if (!rd) begin
			rdata_next = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		s1_reg <= sel_pin;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
		if (rst) begin
			ctrl_reg  <= timer16_pkg::CONTROL_RESET; // R17
			count_reg <= timer16_pkg::COUNT_RESET;
			presc_reg <= timer16_pkg::PRESC_RESET;
			phase_reg <= 2'h0;
			ovf_reg   <= 1'b0;
			armed_reg <= 1'b0;
			rdata_reg <= 8'h00;
			lvl_reg   <= 1'b0;
			osc_reg   <= 1'b0;
		end else begin
			ctrl_reg  <= ctrl_next;
			count_reg <= count_next;
			presc_reg <= presc_next;
			phase_reg <= phase_next;
			ovf_reg   <= ovf_next;
			armed_reg <= armed_next;
			rdata_reg <= rdata_next;
			lvl_reg   <= lvl_next;
			osc_reg   <= osc_next;
		end
	end

	assign rdata = rdata_reg;
	assign count = count_reg;
	assign overflow_flag = ovf_reg;
	assign wake = ovf_reg & sleep & async_mode; // R9
	assign timebase_valid = ~async_mode; // R10

	sequence disarmed_s;
		ctrl_reg.counter_run && ctrl_reg.clock_source_select && !armed_reg;
	endsequence

	sequence fall_seen_s;
		ext_fall ##1 armed_reg;
	endsequence

	timer_rate_a: assert property (@(posedge clk) disable iff (rst) // R1
		!ctrl_reg.clock_source_select && ctrl_reg.counter_run && !sleep &&
		ctrl_reg.prescale == 2'h0 && phase_reg == 2'h3 && !wr && count_reg != 16'hFFFF
		|=> count_reg == $past(count_reg) + 16'h0001)
		else $error("timer mode did not step on instruction clock");

	rising_only_a: assert property (@(posedge clk) disable iff (rst) // R3
		ctrl_reg.clock_source_select && !ext_rise && !wr_count |=> $stable(count_reg))
		else $error("external count moved without rising edge");

	arm_edge_a: assert property (@(posedge clk) disable iff (rst) // R4
		disarmed_s and (##0 ext_fall) |-> fall_seen_s or
		(##1 !(ctrl_reg.counter_run && ctrl_reg.clock_source_select)))
		else $error("falling edge did not arm counter");

	no_early_a: assert property (@(posedge clk) disable iff (rst) // R4
		disarmed_s |-> !inc)
		else $error("count before first falling edge");

	sync_sleep_a: assert property (@(posedge clk) disable iff (rst) // R8
		sleep && !ctrl_reg.ext_sync_disable && !wr_count |=> $stable(count_reg))
		else $error("synced count moved in sleep");

	async_wake_a: assert property (@(posedge clk) disable iff (rst) // R9
		async_mode && sleep && inc && count_reg == 16'hFFFF && !wr_count
		##1 sleep && async_mode |-> wake)
		else $error("async overflow in sleep did not wake");

	timebase_off_a: assert property (@(posedge clk) disable iff (rst) // R10
		ctrl_reg.clock_source_select && ctrl_reg.ext_sync_disable |-> !timebase_valid)
		else $error("async mode offered time base");

	presc_clear_a: assert property (@(posedge clk) disable iff (rst) // R16
		wr_count |=> presc_reg == 3'h0)
		else $error("prescaler not cleared by count write");

	ctrl_reset_a: assert property (@(posedge clk) // R17
		rst |=> ctrl_reg == 8'h00)
		else $error("control not cleared on reset");

	hold_stop_a: assert property (@(posedge clk) disable iff (rst) // R18
		!ctrl_reg.counter_run && !wr_count |=> $stable(count_reg))
		else $error("count moved while stopped");

	wrap_flag_a: assert property (@(posedge clk) disable iff (rst) // R19
		inc && !wr_count && count_reg == 16'hFFFF |=> count_reg == 16'h0000 && ovf_reg)
		else $error("wrap did not zero count and set flag");

	// timer mode: the core clock stops in sleep, so nothing counts

	timer_sleep_a: assert property (@(posedge clk) disable iff (rst) // R1
		!ctrl_reg.clock_source_select && sleep
		|-> !inc)
		else $error("timer mode stepped in sleep");

	arm_clear_a: assert property (@(posedge clk) disable iff (rst) // R4
		!(ctrl_reg.counter_run && ctrl_reg.clock_source_select)
		|=> !armed_reg)
		else $error("arming kept while not counting edges");

	// the sampler must look at the pin the enable bit picks

	xtal_route_a: assert property (@(posedge clk) disable iff (rst) // R5
		ctrl_reg.crystal_osc_enable
		|=> s1_reg == $past(crystal_input_pin))
		else $error("crystal pin not routed to sampler");

	ext_route_a: assert property (@(posedge clk) disable iff (rst) // R5
		!ctrl_reg.crystal_osc_enable
		|=> s1_reg == $past(ext_clock_pin))
		else $error("clock pin not routed to sampler");

	presc_sleep_a: assert property (@(posedge clk) disable iff (rst) // R8
		ctrl_reg.clock_source_select && !ctrl_reg.ext_sync_disable && sleep &&
		ctrl_reg.counter_run && src_tick && !presc_out && !wr_count
		|=> presc_reg == $past(presc_reg) + 3'h1)
		else $error("prescaler stalled in synced sleep");

	async_sleep_a: assert property (@(posedge clk) disable iff (rst) // R9
		async_mode && sleep && inc && !wr_count && count_reg != timer16_pkg::COUNT_MAX
		|=> count_reg == $past(count_reg) + 16'h0001)
		else $error("async count did not step in sleep");

	// wake only makes sense for the free-running async counter

	wake_off_a: assert property (@(posedge clk) disable iff (rst) // R9
		!async_mode || !sleep
		|-> !wake)
		else $error("wake raised outside async sleep");

	timebase_on_a: assert property (@(posedge clk) disable iff (rst) // R10
		!async_mode
		|-> timebase_valid)
		else $error("time base withheld outside async mode");

	read_lo_a: assert property (@(posedge clk) disable iff (rst) // R11
		rd && addr == timer16_pkg::ADDR_COUNT_LO
		|=> rdata == $past(count_reg[7:0]))
		else $error("low byte read returned wrong data");

	read_hi_a: assert property (@(posedge clk) disable iff (rst) // R11
		rd && addr == timer16_pkg::ADDR_COUNT_HI
		|=> rdata == $past(count_reg[15:8]))
		else $error("high byte read returned wrong data");

	read_idle_a: assert property (@(posedge clk) disable iff (rst) // R11
		!rd
		|=> rdata == 8'h00)
		else $error("read data left standing");

	// a count write must land whole even against an increment

	count_lo_a: assert property (@(posedge clk) disable iff (rst) // R13
		wr && addr == timer16_pkg::ADDR_COUNT_LO
		|=> count_reg == {$past(count_reg[15:8]), $past(wdata)})
		else $error("low byte write did not land");

	count_hi_a: assert property (@(posedge clk) disable iff (rst) // R13
		wr && addr == timer16_pkg::ADDR_COUNT_HI
		|=> count_reg == {$past(wdata), $past(count_reg[7:0])})
		else $error("high byte write did not land");

	// amplifier output is the registered inverse of its input

	osc_follow_a: assert property (@(posedge clk) disable iff (rst) // R14
		ctrl_reg.crystal_osc_enable
		|=> crystal_output_pin == !$past(crystal_input_pin))
		else $error("crystal amplifier did not invert input");

	osc_off_a: assert property (@(posedge clk) disable iff (rst) // R14
		!ctrl_reg.crystal_osc_enable
		|=> !crystal_output_pin)
		else $error("crystal amplifier driven while disabled");

	read_ctrl_a: assert property (@(posedge clk) disable iff (rst) // R17
		rd && addr == timer16_pkg::ADDR_CONTROL
		|=> rdata == $past(ctrl_reg))
		else $error("control read returned wrong data");

	ctrl_write_a: assert property (@(posedge clk) disable iff (rst) // R18
		wr && addr == timer16_pkg::ADDR_CONTROL
		|=> ctrl_reg == {2'h0, $past(wdata[5:0])})
		else $error("control write did not land");

	// flag is sticky: only a status write of one clears it, and a wrap wins

	ovf_sticky_a: assert property (@(posedge clk) disable iff (rst) // R19
		ovf_reg && !(wr && addr == timer16_pkg::ADDR_STATUS)
		|=> ovf_reg)
		else $error("overflow flag dropped by itself");

	ovf_clear_a: assert property (@(posedge clk) disable iff (rst) // R19
		wr && addr == timer16_pkg::ADDR_STATUS && wdata[0] && !inc
		|=> !ovf_reg)
		else $error("overflow flag not cleared by status write");
endmodule // timer16

// ---- timer16_pkg.sv ----
// Overview of operation
// R1 - source select clear: count instruction clock
// R2 - timer mode ignores sync control bit
// R3 - external counting advances on rising edges
// R4 - first falling edge needed after enable
// R5 - crystal pin or clock pin per enable
// R6 - sync applied after prescaler, not input
// R7 - prescaler ripples on selected external clock
// R8 - synced mode sleep: count holds, prescaler runs
// R9 - async mode counts in sleep, overflow wakes
// R10 - async mode gives no capture time base
// R11 - count byte reads always valid
// R12 - software handles overflow between byte reads
// R13 - software stops counter before count writes
// R14 - crystal oscillator runs while enabled, sleep too
// R15 - software waits for oscillator start-up
// R16 - count byte writes clear the prescaler
// R17 - power-on reset clears control register
// R18 - counts only while run bit set
// R19 - wraps to zero, sets overflow flag
package timer16_pkg;
	localparam logic [1:0] ADDR_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_COUNT_LO = 2'h1;
	localparam logic [1:0] ADDR_COUNT_HI = 2'h2;
	localparam logic [1:0] ADDR_STATUS = 2'h3;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam int BIT_RUN = 0;
	localparam int BIT_SRC = 1;
	localparam int BIT_SYNC_DIS = 2;
	localparam int BIT_OSC_EN = 3;
	localparam int BIT_PS_LO = 4;
	localparam int BIT_OVF = 0;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [2:0] PRESC_RESET = 3'h0;

	typedef struct packed {
		logic [1:0] unused;
		logic [1:0] prescale;
		logic       crystal_osc_enable;
		logic       ext_sync_disable;
		logic       clock_source_select;
		logic       counter_run;
	} timer_control_s;
endpackage

// ---- ext_source.sv ----
`timescale 1ns/1ps
module ext_source (
	input  wire logic clk,
	output logic      ext_clock_pin,
	output logic      crystal_input_pin
);
	// lines stand still between bursts, each level held well past the 3-flop sampler
	initial begin
		ext_clock_pin = 1'b0;
		crystal_input_pin = 1'b0;
	end
	task automatic level(input logic xtal, input logic v);
		@(posedge clk);
		if (xtal) crystal_input_pin <= v;
		else ext_clock_pin <= v;
		repeat (6) @(posedge clk);
	endtask
	task automatic pulses(input logic xtal, input int n);
		repeat (n) begin
			level(xtal, 1'b0);
			level(xtal, 1'b1);
		end
	endtask
endmodule // ext_source

// ---- timer16_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin err_total++; \
	$display("BAD %s exp %h got %h", nm, e, a); end end
module timer16_test;
	logic        clk, rst, sleep, wr, rd, ext_clock_pin, crystal_input_pin;
	logic        crystal_output_pin, crystal_output_oe, overflow_flag, wake, timebase_valid;
	logic [1:0]  addr;
	logic [7:0]  wdata, rdata, v;
	logic [15:0] count, c0, whole;
	int          err_total = 0;
	int          n_checks = 0;
	timer16 i_dut (.clk, .rst, .sleep, .addr, .wdata, .wr, .rd, .rdata, .ext_clock_pin,
		.crystal_input_pin, .crystal_output_pin, .crystal_output_oe, .overflow_flag,
		.wake, .timebase_valid, .count);
	ext_source i_src (.clk, .ext_clock_pin, .crystal_input_pin);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// high, low, high again: a carry between the byte reads forces a fresh low byte
	task automatic rd_count(output logic [15:0] d);
		logic [7:0] h0, lo, h1;
		rd_reg(timer16_pkg::ADDR_COUNT_HI, h0);
		rd_reg(timer16_pkg::ADDR_COUNT_LO, lo);
		rd_reg(timer16_pkg::ADDR_COUNT_HI, h1);
		if (h1 != h0) rd_reg(timer16_pkg::ADDR_COUNT_LO, lo);
		d = {h1, lo};
	endtask
	task automatic wctl(input logic [7:0] d);
		wr_reg(timer16_pkg::ADDR_CONTROL, d);
	endtask
	// stop first: a write racing an increment may leave a garbled count
	task automatic set_count(input logic [15:0] d);
		wctl(8'h00);
		wr_reg(timer16_pkg::ADDR_COUNT_LO, d[7:0]);
		wr_reg(timer16_pkg::ADDR_COUNT_HI, d[15:8]);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge clk);
		err_total++;
		complete_run;
	end
	initial begin
		rst = 1'b1;
		sleep = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 2'h0;
		wdata = 8'h00;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd_reg(timer16_pkg::ADDR_CONTROL, v);
		`CHK("control", timer16_pkg::CONTROL_RESET, v)
		`CHK("timebase", 1'b1, timebase_valid)
		wctl(8'h05);
		repeat (40) @(posedge clk);
		wctl(8'h04);
		`CHK("rate", 1'b1, count >= 16'h0009 && count <= 16'h000B)
		c0 = count;
		repeat (20) @(posedge clk);
		`CHK("hold", c0, count)
		rd_reg(timer16_pkg::ADDR_COUNT_LO, v);
		`CHK("low byte", c0[7:0], v)
		rd_count(whole);
		`CHK("whole", c0, whole)
		set_count(16'hFFFF);
		wctl(8'h01);
		repeat (8) @(posedge clk);
		`CHK("wrap", 1'b1, count < 16'h0003)
		rd_reg(timer16_pkg::ADDR_STATUS, v);
		`CHK("ovf set", 8'h01, v)
		`CHK("ovf pin", 1'b1, overflow_flag)
		wr_reg(timer16_pkg::ADDR_STATUS, 8'h01);
		rd_reg(timer16_pkg::ADDR_STATUS, v);
		`CHK("ovf clr", 8'h00, v)
		`CHK("ovf pin clr", 1'b0, overflow_flag)
		set_count(16'h0000);
		wctl(8'h03);
		i_src.level(1'b0, 1'b1);
		`CHK("unarmed", 16'h0000, count)
		i_src.pulses(1'b0, 3);
		`CHK("ext", 16'h0003, count)
		i_src.pulses(1'b1, 2);
		`CHK("xtal off", 16'h0003, count)
		wctl(8'h0B);
		`CHK("osc oe", 1'b1, crystal_output_oe)
		repeat (20) @(posedge clk);
		i_src.level(1'b1, 1'b0);
		`CHK("osc out", 1'b1, crystal_output_pin)
		i_src.pulses(1'b1, 2);
		i_src.pulses(1'b0, 2);
		`CHK("xtal src", 16'h0005, count)
		set_count(16'h0000);
		wctl(8'h13);
		i_src.pulses(1'b0, 4);
		`CHK("presc", 16'h0002, count)
		i_src.pulses(1'b0, 1);
		wr_reg(timer16_pkg::ADDR_COUNT_LO, 8'h10);
		i_src.pulses(1'b0, 1);
		`CHK("presc clr", 16'h0010, count)
		wctl(8'h03);
		sleep <= 1'b1;
		i_src.pulses(1'b0, 2);
		`CHK("sync sleep", 16'h0010, count)
		`CHK("no wake", 1'b0, wake)
		sleep <= 1'b0;
		set_count(16'hFFFF);
		wctl(8'h07);
		sleep <= 1'b1;
		`CHK("async tb", 1'b0, timebase_valid)
		i_src.pulses(1'b0, 1);
		`CHK("async cnt", 16'h0000, count)
		`CHK("wake", 1'b1, wake)
		complete_run;
	end
endmodule // timer16_test
